// ### logic/tsa_slot_assigner.sv
// module: tdm slot capture and insert, top level
`timescale 1ns/100ps
`default_nettype none
module tsa_slot_assigner (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       line_clk,
  input  wire logic       frame_sync,
  input  wire logic       line_in,
  output logic            line_out,
  output logic            line_oe_n,
  input  wire logic [5:0] slot_select,
  input  wire logic       tx_enable,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  ////////////////////////////////////////////////////////////////////////
  // pin sampling: three flops, change accepted when 2nd and 3rd agree
  logic [2:0] clk_s_ff, sync_s_ff, din_s_ff;
  logic       clk_lvl_ff, nxt_clk_lvl;
  logic       sync_lvl_ff, nxt_sync_lvl;
  logic       din_lvl_ff, nxt_din_lvl;
  logic       rise, fall;

  always_comb begin
    nxt_clk_lvl  = (clk_s_ff[1] == clk_s_ff[2]) ? clk_s_ff[2] : clk_lvl_ff;
    nxt_sync_lvl = (sync_s_ff[1] == sync_s_ff[2]) ? sync_s_ff[2] : sync_lvl_ff;
    nxt_din_lvl  = (din_s_ff[1] == din_s_ff[2]) ? din_s_ff[2] : din_lvl_ff;
  end
  assign rise = nxt_clk_lvl && !clk_lvl_ff;
  assign fall = !nxt_clk_lvl && clk_lvl_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      clk_s_ff    <= 3'h0;
      sync_s_ff   <= 3'h0;
      din_s_ff    <= 3'h0;
      clk_lvl_ff  <= 1'b0;
      sync_lvl_ff <= 1'b0;
      din_lvl_ff  <= 1'b0;
    end else begin
      clk_s_ff    <= {clk_s_ff[1:0], line_clk};
      sync_s_ff   <= {sync_s_ff[1:0], frame_sync};
      din_s_ff    <= {din_s_ff[1:0], line_in};
      clk_lvl_ff  <= nxt_clk_lvl;
      sync_lvl_ff <= nxt_sync_lvl;
      din_lvl_ff  <= nxt_din_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit buffer: local words wait here until the slot comes round
  tsa_fifo_if txq ();
  tsa_fifo #(.WIDTH(tsa_pkg::WORD_W), .DEPTH(tsa_pkg::FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .in_valid (tx_valid),
    .in_ready (tx_ready),
    .in_data  (tx_data),
    .out      (txq)
  );

  ////////////////////////////////////////////////////////////////////////
  // slot timing: sync high marks slot 0; counting is on line clock rises
  tsa_pkg::tsa_state_t st_ff, nxt_st;
  logic [5:0] slot_ff, nxt_slot;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] rx_sh_ff, nxt_rx_sh, rx_data_ff, nxt_rx_data;
  logic [7:0] tx_sh_ff, nxt_tx_sh;
  logic       rx_valid_ff, nxt_rx_valid;
  logic       tx_act_ff, nxt_tx_act;
  logic       out_ff, nxt_out, oe_n_ff, nxt_oe_n;
  logic       sel_hit, pop;
  logic       sync_rise_ff, nxt_sync_rise;
  logic [5:0] cur_slot;
  logic [2:0] cur_bit;
  logic       frame_start, step;

  function automatic logic slot_match(input logic [5:0] cnt, input logic [5:0] sel);
    slot_match = cnt == sel; // R4
  endfunction : slot_match

  // frame opens at the first rise finding sync high after one that found it low
  assign frame_start = rise && sync_lvl_ff && !sync_rise_ff; // R10
  assign step        = rise && (st_ff == tsa_pkg::TSA_RUN
                                || (st_ff == tsa_pkg::TSA_SYNC && frame_start));
  assign cur_slot    = frame_start ? tsa_pkg::SLOT_RST : slot_ff;
  assign cur_bit     = frame_start ? tsa_pkg::BIT_RST : bit_ff;
  assign sel_hit     = slot_match(cur_slot, slot_select);
  assign pop         = tx_enable && step && cur_bit == tsa_pkg::BIT_RST && sel_hit;
  assign txq.ready   = pop;

  always_comb begin
    nxt_st       = st_ff;
    nxt_slot     = slot_ff;
    nxt_bit      = bit_ff;
    nxt_rx_sh    = rx_sh_ff;
    nxt_rx_data  = rx_data_ff;
    nxt_rx_valid = rx_valid_ff;
    nxt_tx_sh    = tx_sh_ff;
    nxt_tx_act   = tx_act_ff;
    nxt_out      = out_ff;
    nxt_oe_n     = oe_n_ff;
    nxt_sync_rise = rise ? sync_lvl_ff : sync_rise_ff;
    case (st_ff)
      tsa_pkg::TSA_HUNT: begin
        if (sync_lvl_ff) begin
          nxt_st = tsa_pkg::TSA_SYNC;
        end
      end
      tsa_pkg::TSA_SYNC: begin
        // the opening rise is bit 0 of slot 0, so it is counted, not lost
        if (frame_start) begin
          nxt_st = tsa_pkg::TSA_RUN;
        end
      end
      tsa_pkg::TSA_RUN: begin
        nxt_st = tsa_pkg::TSA_RUN;
      end
      default: begin
        nxt_st = tsa_pkg::TSA_HUNT;
      end
    endcase
    if (step) begin
      // shift only inside the chosen slot
      if (sel_hit) begin
        nxt_rx_sh = {rx_sh_ff[6:0], din_lvl_ff}; // R5 R2
        if (cur_bit == tsa_pkg::BIT_RST) begin
          nxt_rx_valid = 1'b0; // R11
        end
        if (cur_bit == tsa_pkg::BIT_LAST) begin
          nxt_rx_data  = {rx_sh_ff[6:0], din_lvl_ff};
          nxt_rx_valid = 1'b1; // R6 R11
        end
      end
      nxt_bit  = cur_bit + 3'h1;
      nxt_slot = (cur_bit == tsa_pkg::BIT_LAST) ? cur_slot + 6'h01 : cur_slot; // R10 R1
    end
    // drive starts at the slot's first rise, from the buffered word
    if (pop) begin
      nxt_tx_act = txq.valid; // R7
      nxt_tx_sh  = {txq.data[6:0], 1'b0};
      nxt_out    = txq.data[7];
      nxt_oe_n   = !txq.valid;
    end else if (step && tx_act_ff) begin
      nxt_out   = tx_sh_ff[7];
      nxt_tx_sh = {tx_sh_ff[6:0], 1'b0};
    end
    // release after the eighth bit, at the falling edge following it
    if (fall && tx_act_ff && bit_ff == tsa_pkg::BIT_RST && !sel_hit) begin
      nxt_tx_act = 1'b0;
      nxt_oe_n   = 1'b1; // R8
    end
    if (st_ff == tsa_pkg::TSA_RUN && slot_ff >= 6'(tsa_pkg::SLOTS_MAX) + 6'h08) begin
      nxt_st     = tsa_pkg::TSA_HUNT; // lost sync: wait for next frame
      nxt_oe_n   = 1'b1;
      nxt_tx_act = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff       <= tsa_pkg::TSA_HUNT;
      slot_ff     <= tsa_pkg::SLOT_RST;
      bit_ff      <= tsa_pkg::BIT_RST;
      rx_sh_ff    <= tsa_pkg::WORD_RST;
      rx_data_ff  <= tsa_pkg::WORD_RST;
      rx_valid_ff <= 1'b0;
      tx_sh_ff    <= tsa_pkg::WORD_RST;
      tx_act_ff   <= 1'b0;
      out_ff      <= 1'b0;
      oe_n_ff     <= 1'b1;
      // set: a sync already high at release is mid-pulse, not a frame start
      sync_rise_ff <= 1'b1;
    end else begin
      sync_rise_ff <= nxt_sync_rise;
      st_ff       <= nxt_st;
      slot_ff     <= nxt_slot;
      bit_ff      <= nxt_bit;
      rx_sh_ff    <= nxt_rx_sh;
      rx_data_ff  <= nxt_rx_data;
      rx_valid_ff <= nxt_rx_valid;
      tx_sh_ff    <= nxt_tx_sh;
      tx_act_ff   <= nxt_tx_act;
      out_ff      <= nxt_out;
      oe_n_ff     <= nxt_oe_n;
    end
  end

  // R3: 25 MHz sampling gives LINE_MIN_CYC cycles per line bit at most rate
  assign line_out  = out_ff;
  assign line_oe_n = oe_n_ff;
  assign rx_valid  = rx_valid_ff;
  assign rx_data   = rx_data_ff;
endmodule : tsa_slot_assigner
`default_nettype wire

// ### logic/tsa_pkg.sv
// package: constants and types for the tdm slot capture/insert block
//
// Behaviour
// (R1) frame splits into a number of slots, from 24 up to 40
// (R2) every slot carries exactly eight bits, one per data clock
// (R3) slot logic keeps up with 2.56 MHz data clock, forty slots
// (R4) the six slot_select inputs choose the slot to capture or drive
// (R5) shift line data into the capture register during the selected slot only
// (R6) after the selected slot is shifted in, raise valid-data
// (R7) load a parallel word and shift it onto the line in the slot
// (R8) line driver released (high impedance) outside the assigned slot
// (R9) frame sync is an 8 kHz pulse, eight data clocks long
// (R10) slot counter restarts on frame sync, advances every eight clocks
// (R11) valid-data stays low while shifting, high only after all eight bits
`default_nettype none
package tsa_pkg;
  localparam int unsigned WORD_W      = 8;
  localparam int unsigned SEL_W       = 6;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned SLOTS_MIN   = 24;
  localparam int unsigned SLOTS_MAX   = 40;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [5:0]  SLOT_RST    = 6'h00;
  localparam logic [2:0]  BIT_RST     = 3'h0;
  localparam logic [7:0]  WORD_RST    = 8'h00;
  localparam int unsigned CLK_HZ      = 25000000;
  localparam int unsigned LINE_HZ_MAX = 2560000;
  localparam int unsigned LINE_MIN_CYC = (CLK_HZ + LINE_HZ_MAX - 1) / LINE_HZ_MAX;

  typedef enum logic [2:0] {
    TSA_HUNT = 3'b001,
    TSA_RUN  = 3'b010,
    TSA_SYNC = 3'b100
  } tsa_state_t;
endpackage : tsa_pkg
`default_nettype wire

// ### logic/tsa_fifo_if.sv
// interface: valid/ready stream between fifo and slot logic
`timescale 1ns/100ps
`default_nettype none
interface tsa_fifo_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : tsa_fifo_if
`default_nettype wire

// ### logic/tsa_fifo.sv
// module: parameterised valid/ready fifo
`timescale 1ns/100ps
`default_nettype none
module tsa_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  tsa_fifo_if.src               out
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  assign in_ready  = cnt_ff < (AW+1)'(DEPTH);
  assign out.valid = cnt_ff != '0;
  assign out.data  = mem_ff[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out.valid && out.ready;

  always_comb begin
    nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule : tsa_fifo
`default_nettype wire

// ### bench/tsa_slot_assigner_asserts.sv
// checker: port timing of the slot assigner
`timescale 1ns/100ps
`default_nettype none
module tsa_slot_assigner_asserts (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       line_clk,
  input wire logic       line_oe_n,
  input wire logic       tx_enable,
  input wire logic       tx_ready,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data
);
  logic       lclk_ff;
  logic       fell_ff;
  logic [3:0] oe_cnt_ff;
  logic [3:0] rx_cnt_ff;
  // raw line rises, seen ahead of the design's synchroniser
  always_ff @(posedge clk) begin
    lclk_ff   <= line_clk;
    fell_ff   <= resetn && (fell_ff || $fell(rx_valid));
    oe_cnt_ff <= line_oe_n ? 4'h0 : oe_cnt_ff + {3'h0, line_clk && !lclk_ff};
    rx_cnt_ff <= rx_valid ? 4'h0 : rx_cnt_ff + {3'h0, line_clk && !lclk_ff};
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////
  property p_rst;
    disable iff (1'b0) !resetn |=> line_oe_n && !rx_valid && tx_ready;
  endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_oe_bits;
    oe_cnt_ff <= 4'h7;
  endproperty
  a_oe_bits: assert property (p_oe_bits) else $error("driver held past slot");
  property p_oe_cause;
    $fell(line_oe_n) |-> $past(tx_enable);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drove while disabled");
  property p_oe_span;
    $fell(line_oe_n) |=> !line_oe_n [*8];
  endproperty
  a_oe_span: assert property (p_oe_span) else $error("slot drive too short");
  property p_oe_gap;
    $rose(line_oe_n) |=> line_oe_n [*8];
  endproperty
  a_oe_gap: assert property (p_oe_gap) else $error("driver not released");
  property p_rx_bits;
    $rose(rx_valid) && fell_ff |-> rx_cnt_ff == 4'h7;
  endproperty
  a_rx_bits: assert property (p_rx_bits) else $error("valid not after 8 bits");
  property p_rx_hold;
    rx_valid && $past(rx_valid) |-> $stable(rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("word moved while valid");
  property p_rx_min;
    $rose(rx_valid) |=> rx_valid [*8];
  endproperty
  a_rx_min: assert property (p_rx_min) else $error("valid too short");
endmodule : tsa_slot_assigner_asserts
bind tsa_slot_assigner tsa_slot_assigner_asserts i_tsa_slot_assigner_asserts (.clk(clk),
  .resetn(resetn), .line_clk(line_clk), .line_oe_n(line_oe_n), .tx_enable(tx_enable),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
`default_nettype wire

// ### bench/tsa_bus_model.sv
// model: tdm line with sync, data clock and other slot sources
`timescale 1ns/100ps
`default_nettype none
module tsa_bus_model #(
  parameter int unsigned N_SLOTS = 24,
  parameter int unsigned HALF_NS = 320  // 1.5625 MHz, under the 2.56 MHz ceiling
) (
  input  wire logic       clk,
  input  wire logic       line_out,
  input  wire logic       line_oe_n,
  input  wire logic [5:0] mute_slot,
  input  wire logic       mute,
  output logic            line_clk,
  output logic            frame_sync,
  output logic            line_in,
  output logic [7:0]      frm
);
  logic [7:0] seen [0:63];
  logic [7:0] w;
  logic [5:0] slot;
  logic       other;
  logic       junk_ff = 1'b0;
  // a released slot floats: toggle so a stale bit never passes
  always @(posedge clk) junk_ff <= ~junk_ff;
  assign line_in = !line_oe_n ? line_out : (mute && slot == mute_slot) ? junk_ff : other;
  initial begin
    {line_clk, frame_sync, other, frm, slot} = '0;
    forever begin
      for (int k = 0; k < N_SLOTS * 8; k++) begin
        #(HALF_NS);
        line_clk = 1'b0;
        seen[slot] = {seen[slot][6:0], line_in};
        slot = 6'(k / 8);
        frame_sync = (k < 8);
        if (k == 0) frm = frm + 8'h01;
        w = {frm[1:0], slot};
        other = w[3'(7 - k % 8)];
        #(HALF_NS);
        line_clk = 1'b1;
      end
    end
  end
endmodule : tsa_bus_model
`default_nettype wire

// ### bench/tsa_slot_assigner_tb.sv
// testbench: capture and insert through the slot assigner
`timescale 1ns/100ps
`default_nettype none
module tsa_slot_assigner_tb;
  logic       clk = 1'b0;
  logic       resetn, tx_enable, tx_valid, mute, line_clk, frame_sync, line_in;
  logic       line_out, line_oe_n, tx_ready, rx_valid;
  logic [5:0] slot_select;
  logic [7:0] tx_data, rx_data, frm;
  int         failures = 0, n_tests = 0, cycles = 0, n;
  always #20 clk = ~clk;
  tsa_slot_assigner i_tsa_slot_assigner (.clk(clk), .resetn(resetn), .line_clk(line_clk),
    .frame_sync(frame_sync), .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n),
    .slot_select(slot_select), .tx_enable(tx_enable), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data));
  tsa_bus_model i_tsa_bus_model (.clk(clk), .line_out(line_out), .line_oe_n(line_oe_n),
    .mute_slot(slot_select), .mute(mute), .line_clk(line_clk), .frame_sync(frame_sync),
    .line_in(line_in), .frm(frm));
  //////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // about 20 frames of 3072 cycles are needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      failures++;
      complete_run();
    end
  end
  task automatic next_frame;
    @(frm);
    @(negedge clk);
  endtask : next_frame
  //////////////////////////////////////////////////
  task automatic test_rx;
    int sels[3] = '{23, 9, 0};
    foreach (sels[i]) begin
      slot_select = 6'(sels[i]);
      next_frame();
      wait (!rx_valid);
      wait (rx_valid);
      @(negedge clk);
      check(rx_data, {frm[1:0], slot_select});
      check(line_oe_n, 1'b1);
    end
    $display("capture test done");
  endtask : test_rx
  task automatic test_tx;
    mute = 1'b1;
    slot_select = 6'h07;
    next_frame();
    n = 0;
    while (tx_ready && n < 20) begin
      tx_valid = 1'b1;
      tx_data = {4'(n), ~4'(n)};
      @(negedge clk);
      n++;
    end
    tx_data = 8'hee;
    @(negedge clk);
    tx_valid = 1'b0;
    tx_enable = 1'b1;
    check(8'(n), 8'h10);
    for (int i = 0; i < 16; i++) begin
      next_frame();
      check(i_tsa_bus_model.seen[7], {4'(i), ~4'(i)});
      check(i_tsa_bus_model.seen[6], {frm[1:0] - 2'h1, 6'h06});
    end
    check(tx_ready, 1'b1);
    $display("insert test done");
  endtask : test_tx
  initial begin
    resetn = 1'b0;
    tx_enable = 1'b0;
    tx_valid = 1'b0;
    mute = 1'b0;
    slot_select = 6'h00;
    tx_data = 8'h00;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    check(line_oe_n, 1'b1);
    check(rx_valid, 1'b0);
    check(tx_ready, 1'b1);
    $display("reset test done");
    test_rx();
    test_tx();
    complete_run();
  end
endmodule : tsa_slot_assigner_tb
`default_nettype wire
